// ===== logic/ssic_ctrl.sv
// Purpose: Interrupt controller end: flags, masks, enable, priority, vector
// Assumes: Core end drives bit accesses, acknowledge and return pulses
// Notes:   Control words answer at RAM words 0x000..0x003 only
`timescale 1ns/1ps
`include "ssic_regs.svh"

module ssic_ctrl
	import ssic_pkg::*;
#(
	parameter int NUM_SRC   = `SSIC_NUM_SRC,
	parameter int EDGE_HOLD = `SSIC_EDGE_HOLD
) (
	input  wire logic sys_clk_i,       // Instruction clock
	input  wire logic nrst_i,          // MCU reset, active low
	ssic_if.ctrl      lnk,             // Link to core sequencer
	input  wire logic ext0_n_i,        // External line zero, active low
	input  wire logic ext1_n_i,        // External line one, active low
	input  wire logic timer_a_ovf_i,   // Timer A overflow pulse
	input  wire logic timer_b_ovf_i,   // Timer B overflow pulse
	input  wire logic timer_c_ovf_i,   // Timer C overflow pulse
	input  wire logic serial_eighth_i, // Eighth transfer clock pulse
	input  wire logic serial_abort_i,  // Bit counter reset pulse
	output logic      timer_b_evt_o,   // Timer B event clock pulse
	output logic      global_irq_enable_o // Global enable state
);

	localparam int PW = 4;

	// Flat bit position of flag k; its mask sits one above
	function automatic logic [PW-1:0] flag_pos(input int k);
		flag_pos = `SSIC_POS_EXT0_FLAG + PW'(k) * `SSIC_POS_STRIDE;
	endfunction

	// Flat bit position of the mask of source k
	function automatic logic [PW-1:0] mask_pos(input int k);
		mask_pos = flag_pos(k) + 4'h1;
	endfunction

	// Vector of source k: base plus k steps
	function automatic logic [`SSIC_VEC_W-1:0] vec_of(input int k);
		vec_of = `SSIC_VEC_BASE + `SSIC_VEC_W'(k) * `SSIC_VEC_STEP;
	endfunction

	logic                   global_irq_enable;
	logic [NUM_SRC-1:0]     request_flag;
	logic [NUM_SRC-1:0]     request_mask;
	logic [NUM_SRC-1:0]     next_flag;
	logic [NUM_SRC-1:0]     next_mask;
	logic                   next_ie;
	logic [NUM_SRC-1:0]     hw_set;
	logic [NUM_SRC-1:0]     sw_clr;
	logic [NUM_SRC-1:0]     sw_set_mask;
	logic [NUM_SRC-1:0]     sw_clr_mask;
	logic [NUM_SRC-1:0]     pending;
	logic [NUM_SRC-1:0]     serviceable;
	logic [15:0]            image;
	logic [`SSIC_VEC_W-1:0] win_vec;
	logic                   win_any;
	logic                   ext0_fall;
	logic                   ext1_fall;

	// Pin edge filters; glitches under the hold time are dropped
	// A rise must hold as long before the next fall counts
	ssic_edge_det #(.HOLD(EDGE_HOLD)) u_edge0 (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.level_i   (ext0_n_i),
		.fall_o    (ext0_fall)
	);

	ssic_edge_det #(.HOLD(EDGE_HOLD)) u_edge1 (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.level_i   (ext1_n_i),
		.fall_o    (ext1_fall)
	);

	// Hardware events, in priority order
	assign hw_set[0] = ext0_fall;
	assign hw_set[1] = ext1_fall;
	assign hw_set[2] = timer_a_ovf_i;
	assign hw_set[3] = timer_b_ovf_i;
	assign hw_set[4] = timer_c_ovf_i;
	assign hw_set[5] = serial_eighth_i | serial_abort_i;

	// Bit access decode; anything above word 3 is not ours
	wire          in_range = lnk.bit_req && (lnk.bit_addr <= `SSIC_WORD3_ADDR);
	wire [PW-1:0] pos      = {lnk.bit_addr[1:0], lnk.bit_sel};
	wire          do_set   = in_range && (lnk.bit_op == SSIC_OP_SET);
	wire          do_clr   = in_range && (lnk.bit_op == SSIC_OP_CLEAR);
	wire          do_test  = lnk.bit_req && (lnk.bit_op == SSIC_OP_TEST);

	// Per-source strobes; a software set on a flag has no path at all
	always_comb begin
		for (int k = 0; k < NUM_SRC; k++) begin
			sw_clr[k]      = do_clr && (pos == flag_pos(k));
			sw_set_mask[k] = do_set && (pos == mask_pos(k));
			sw_clr_mask[k] = do_clr && (pos == mask_pos(k));
		end
	end

	// Set wins when an event meets a clear in one cycle
	assign next_flag = hw_set | (request_flag & ~sw_clr);
	assign next_mask = (request_mask | sw_set_mask) & ~sw_clr_mask;

	// Acknowledge drops enable, return or a bit set raises it
	// Clear beats set, so a return meeting an ack leaves it off
	wire ie_hit = (pos == `SSIC_POS_IE);
	wire ie_set = lnk.return_from_handler_instr || (do_set && ie_hit);
	wire ie_clr = lnk.ack || (do_clr && ie_hit);
	assign next_ie = ie_clr ? 1'b0 : (ie_set ? 1'b1 : global_irq_enable);

	// Requesting sources and the ones the enable lets through
	assign pending     = request_flag & ~request_mask;
	assign serviceable = global_irq_enable ? pending : '0;

	// Fixed priority: lowest index wins, lower ranks are don't-care
	always_comb begin
		win_any = 1'b0;
		win_vec = '0;
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			if (serviceable[k]) begin
				win_any = 1'b1;
				win_vec = vec_of(k);
			end
		end
	end

	// Readable image of the four words; the spare bit reads zero
	// Words beyond the fourth never reach it, the answer path gates them
	always_comb begin
		image                 = '0;
		image[`SSIC_POS_IE]   = global_irq_enable;
		image[`SSIC_POS_RSVD] = 1'b0;
		for (int k = 0; k < NUM_SRC; k++) begin
			image[flag_pos(k)]        = request_flag[k];
			image[mask_pos(k)]        = request_mask[k];
		end
	end

	// Control state; masks come up set so nothing fires early
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			global_irq_enable <= `SSIC_RST_IE;
			request_flag      <= `SSIC_RST_FLAGS;
			request_mask      <= `SSIC_RST_MASKS;
		end else begin
			global_irq_enable <= next_ie;
			request_flag      <= next_flag;
			request_mask      <= next_mask;
		end
	end

	// Request toward core; held off on the ack edge to avoid a double take
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lnk.irq_req <= 1'b0;
			lnk.irq_vec <= '0;
		end else begin
			lnk.irq_req <= win_any && !lnk.ack;
			lnk.irq_vec <= win_vec;
		end
	end

	// Test answers one cycle after the request; unmapped reads zero
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lnk.bit_rdata  <= 1'b0;
			lnk.bit_rvalid <= 1'b0;
		end else begin
			lnk.bit_rvalid <= do_test;
			lnk.bit_rdata  <= do_test && in_range && image[pos];
		end
	end

	// Pin one doubles as timer B clock whether masked or not
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timer_b_evt_o       <= 1'b0;
			global_irq_enable_o <= 1'b0;
		end else begin
			timer_b_evt_o       <= ext1_fall;
			global_irq_enable_o <= next_ie;
		end
	end

endmodule

// ===== common/ssic_regs.svh
// Purpose: Constants for the six-source interrupt control block
// Assumes: Interrupt control words sit at RAM word addresses 0x000..0x003
// Notes:   Bit position inside the block = word index * 4 + bit index
`ifndef SSIC_REGS_SVH
`define SSIC_REGS_SVH

// RAM word addresses of the four control words
`define SSIC_ADDR_W        10
`define SSIC_WORD0_ADDR    10'h000
`define SSIC_WORD1_ADDR    10'h001
`define SSIC_WORD2_ADDR    10'h002
`define SSIC_WORD3_ADDR    10'h003

// Flat bit positions (word * 4 + bit)
`define SSIC_POS_IE        4'h0
`define SSIC_POS_RSVD      4'h1
`define SSIC_POS_EXT0_FLAG 4'h2
`define SSIC_POS_EXT0_MASK 4'h3
`define SSIC_POS_EXT1_FLAG 4'h4
`define SSIC_POS_EXT1_MASK 4'h5
`define SSIC_POS_TA_FLAG   4'h6
`define SSIC_POS_TA_MASK   4'h7
`define SSIC_POS_TB_FLAG   4'h8
`define SSIC_POS_TB_MASK   4'h9
`define SSIC_POS_TC_FLAG   4'hA
`define SSIC_POS_TC_MASK   4'hB
`define SSIC_POS_SER_FLAG  4'hC
`define SSIC_POS_SER_MASK  4'hD
`define SSIC_POS_STRIDE    4'h2

// Reset values
`define SSIC_RST_IE        1'h0
`define SSIC_RST_FLAGS     6'h00
`define SSIC_RST_MASKS     6'h3F

// Vector of the top-priority source, and step between vectors
`define SSIC_VEC_W         16
`define SSIC_VEC_BASE      16'h0002
`define SSIC_VEC_STEP      16'h0002

// Source count and edge hold time in instruction cycles (more than two)
`define SSIC_NUM_SRC       6
`define SSIC_EDGE_HOLD     3

`endif

// ===== common/ssic_pkg.sv
// Purpose: Shared types of the six-source interrupt control block
// Assumes: Constants come from ssic_regs.svh
// Notes:   Source index order equals priority order, index 0 highest
package ssic_pkg;

	// Single-bit access kinds issued by the core
	typedef enum logic [1:0] {
		SSIC_OP_TEST,
		SSIC_OP_SET,
		SSIC_OP_CLEAR,
		SSIC_OP_NONE
	} ssic_op_type;

	// Acknowledge sequence of the core
	typedef enum logic [1:0] {
		SSIC_SEQ_IDLE,
		SSIC_SEQ_C1,
		SSIC_SEQ_C2,
		SSIC_SEQ_C3
	} ssic_seq_type;

endpackage

// ===== common/ssic_if.sv
// Purpose: Link between the interrupt controller and the CPU core sequencer
// Assumes: Both ends run on the same instruction clock
// Notes:   No clocking block; the bench joins the two ends through this
`timescale 1ns/1ps
`include "ssic_regs.svh"

interface ssic_if;
	import ssic_pkg::*;

	logic                     bit_req;   // Core: bit access request
	ssic_op_type              bit_op;    // Core: set, clear or test
	logic [`SSIC_ADDR_W-1:0]  bit_addr;  // Core: RAM word address
	logic [1:0]               bit_sel;   // Core: bit inside the word
	logic                     bit_rdata; // Ctrl: tested bit value
	logic                     bit_rvalid;// Ctrl: test answer strobe
	logic                     irq_req;   // Ctrl: serviceable request
	logic [`SSIC_VEC_W-1:0]   irq_vec;   // Ctrl: vector of the winner
	logic                     ack;       // Core: request acknowledged
	logic                     return_from_handler_instr;      // Core: return from handler

	modport ctrl (
		input  bit_req, bit_op, bit_addr, bit_sel, ack, return_from_handler_instr,
		output bit_rdata, bit_rvalid, irq_req, irq_vec
	);

	modport core (
		output bit_req, bit_op, bit_addr, bit_sel, ack, return_from_handler_instr,
		input  bit_rdata, bit_rvalid, irq_req, irq_vec
	);

endinterface

// ===== logic/ssic_edge_det.sv
// Purpose: Filtered falling-edge detector for one active-low request pin
// Assumes: Pin is synchronous to the instruction clock
// Notes:   A new level counts only after HOLD consecutive samples
`timescale 1ns/1ps

module ssic_edge_det #(
	parameter int HOLD = 3
) (
	input  wire logic sys_clk_i, // Instruction clock
	input  wire logic nrst_i,    // Async reset, active low
	input  wire logic level_i,   // Pin level, idle high
	output logic      fall_o     // One-cycle pulse on accepted fall
);

	localparam int CW = $clog2(HOLD + 1);

	logic          stable;
	logic [CW-1:0] run;
	logic [CW-1:0] next_run;

	// Glitches shorter than the hold time never reach the flag
	wire differs = level_i != stable;
	wire accept  = differs && (run == CW'(HOLD - 1));

	assign next_run = (differs && !accept) ? run + 1'b1 : '0;

	// Stable level tracker; idle level of the pin is high
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stable <= 1'b1;
			run    <= '0;
			fall_o <= 1'b0;
		end else begin
			run    <= next_run;
			fall_o <= accept & ~level_i;
			if (accept) begin
				stable <= level_i;
			end
		end
	end

endmodule

// ===== logic/ssic_core.sv
// Purpose: Core sequencer end: bit access, acknowledge sequence, return
// Assumes: Controller end answers tests one cycle after the request
// Notes:   Software behaviour (jump at vector, flag clear) rides on cmd port
`timescale 1ns/1ps
`include "ssic_regs.svh"

module ssic_core
	import ssic_pkg::*;
(
	input  wire logic                    sys_clk_i,    // Instruction clock
	input  wire logic                    nrst_i,       // MCU reset, active low
	ssic_if.core                         lnk,          // Link to controller
	input  wire logic                    cmd_valid_i,  // Bit instruction strobe
	input  wire ssic_op_type             cmd_op_i,     // Set, clear or test
	input  wire logic [`SSIC_ADDR_W-1:0] cmd_addr_i,   // RAM word address
	input  wire logic [1:0]              cmd_bit_i,    // Bit in the word
	input  wire logic                    return_from_handler_instr_i,       // Return instruction
	output logic                         cmd_rdata_o,  // Tested bit
	output logic                         cmd_rvalid_o, // Test result strobe
	output logic                         finish_o,     // Cycle 1: finish instr
	output logic                         push_o,       // Cycles 2-3: stack push
	output logic                         fetch_o,      // Cycle 3: vector fetch
	output logic [`SSIC_VEC_W-1:0]       fetch_addr_o  // Vector address
);

	ssic_seq_type           seq;
	ssic_seq_type           next_seq;
	logic [`SSIC_VEC_W-1:0] vec_hold;

	// Take a request only from idle; controller masks it during ack
	wire take = (seq == SSIC_SEQ_IDLE) && lnk.irq_req;

	// Acknowledge sequence
	always_comb begin
		case (seq)
			SSIC_SEQ_IDLE: next_seq = take ? SSIC_SEQ_C1 : SSIC_SEQ_IDLE;
			SSIC_SEQ_C1:   next_seq = SSIC_SEQ_C2;
			SSIC_SEQ_C2:   next_seq = SSIC_SEQ_C3;
			SSIC_SEQ_C3:   next_seq = SSIC_SEQ_IDLE;
			default:       next_seq = SSIC_SEQ_IDLE;
		endcase
	end

	// Sequence state and strobes; ack stands through cycle 1 only
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq          <= SSIC_SEQ_IDLE;
			vec_hold     <= '0;
			lnk.ack      <= 1'b0;
			finish_o     <= 1'b0;
			push_o       <= 1'b0;
			fetch_o      <= 1'b0;
			fetch_addr_o <= '0;
		end else begin
			seq          <= next_seq;
			lnk.ack      <= take;
			finish_o     <= take;
			push_o       <= (next_seq == SSIC_SEQ_C2) || (next_seq == SSIC_SEQ_C3);
			fetch_o      <= next_seq == SSIC_SEQ_C3;
			fetch_addr_o <= (next_seq == SSIC_SEQ_C3) ? vec_hold : '0;
			if (take) begin
				vec_hold <= lnk.irq_vec;
			end
		end
	end

	// Bit instructions and return pass through one register stage
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lnk.bit_req  <= 1'b0;
			lnk.bit_op   <= SSIC_OP_NONE;
			lnk.bit_addr <= '0;
			lnk.bit_sel  <= '0;
			lnk.return_from_handler_instr     <= 1'b0;
			cmd_rdata_o  <= 1'b0;
			cmd_rvalid_o <= 1'b0;
		end else begin
			lnk.bit_req  <= cmd_valid_i;
			lnk.bit_op   <= cmd_valid_i ? cmd_op_i : SSIC_OP_NONE;
			lnk.bit_addr <= cmd_addr_i;
			lnk.bit_sel  <= cmd_bit_i;
			lnk.return_from_handler_instr     <= return_from_handler_instr_i;
			cmd_rdata_o  <= lnk.bit_rdata;
			cmd_rvalid_o <= lnk.bit_rvalid;
		end
	end

endmodule

// ===== testbench/ssic_checker.sv
// Purpose: Link-level assertions for the interrupt control pair
// Assumes: One instruction clock, asynchronous active-low reset
// Notes:   Sees only link signals; flag and mask state is judged by the bench
`timescale 1ns/1ps

module ssic_checker
	import ssic_pkg::*;
(
	input  wire logic        sys_clk_i,  // Instruction clock
	input  wire logic        nrst_i,     // Reset, active low
	input  wire logic        bit_req,    // Bit access strobe
	input  wire ssic_op_type bit_op,     // Access kind
	input  wire logic [9:0]  bit_addr,   // Word address
	input  wire logic [1:0]  bit_sel,    // Bit in word
	input  wire logic        bit_rdata,  // Tested bit
	input  wire logic        bit_rvalid, // Test answer strobe
	input  wire logic        irq_req,    // Serviceable request
	input  wire logic [15:0] irq_vec,    // Winner vector
	input  wire logic        ack,        // Acknowledge pulse
	input  wire logic        return_from_handler_instr        // Return pulse, watched only
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// A test access from the core
	sequence s_test;
		bit_req && bit_op == SSIC_OP_TEST;
	endsequence

	// Two quiet cycles after a take, so one event gives one service
	sequence s_quiet;
		!irq_req && !ack ##1 !irq_req && !ack;
	endsequence

	property p_test_ans;
		s_test |=> bit_rvalid;
	endproperty
	a_test_ans: assert property (p_test_ans)
		else $error("test access got no answer");

	property p_no_stray;
		!(bit_req && bit_op == SSIC_OP_TEST) |=> !bit_rvalid;
	endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("answer without a test access");

	property p_oor;
		s_test ##0 (bit_addr > 10'h003) |=> bit_rvalid && !bit_rdata;
	endproperty
	a_oor: assert property (p_oor)
		else $error("unmapped word read nonzero");

	property p_rsvd;
		s_test ##0 (bit_addr == 10'h000 && bit_sel == 2'h1) |=> !bit_rdata;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit read nonzero");

	property p_vec;
		irq_req |-> irq_vec inside {16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C};
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector out of table");

	property p_take;
		$rose(irq_req) |=> ack;
	endproperty
	a_take: assert property (p_take)
		else $error("request not acknowledged");

	property p_quiet;
		ack |=> s_quiet;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("request or ack during sequence");

	property p_cause;
		ack |-> $past(irq_req);
	endproperty
	a_cause: assert property (p_cause)
		else $error("ack without a request");
endmodule

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench joining controller and core ends
// Assumes: Inputs change on falling edges; edge filter hold is 3 samples
// Notes:   ev bits drive ext0, ext1, timer A, B, C, serial; ext pins inverted
`timescale 1ns/1ps

module tb_top
	import ssic_pkg::*;
;
	logic        clk;
	logic        nrst;
	logic [5:0]  ev;
	logic        ab;
	logic        r;
	logic        cv;
	ssic_op_type co;
	logic [9:0]  ca;
	logic [1:0]  cb;
	logic        rd;
	logic        rv;
	logic        fin;
	logic        psh;
	logic        fch;
	logic [15:0] fa;
	logic        tbe;
	logic        ie;
	int          err_total = 0;
	int          checks_done = 0;
	int          nb = 0;

	// 200 MHz instruction clock
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	ssic_if i_ssic_if ();

	ssic_ctrl i_ssic_ctrl (.sys_clk_i(clk), .nrst_i(nrst), .lnk(i_ssic_if),
		.ext0_n_i(~ev[0]), .ext1_n_i(~ev[1]), .timer_a_ovf_i(ev[2]),
		.timer_b_ovf_i(ev[3]), .timer_c_ovf_i(ev[4]), .serial_eighth_i(ev[5]),
		.serial_abort_i(ab), .timer_b_evt_o(tbe), .global_irq_enable_o(ie));

	ssic_core i_ssic_core (.sys_clk_i(clk), .nrst_i(nrst), .lnk(i_ssic_if),
		.cmd_valid_i(cv), .cmd_op_i(co), .cmd_addr_i(ca), .cmd_bit_i(cb), .return_from_handler_instr_i(r),
		.cmd_rdata_o(rd), .cmd_rvalid_o(rv), .finish_o(fin), .push_o(psh),
		.fetch_o(fch), .fetch_addr_o(fa));

	ssic_checker i_ssic_checker (.sys_clk_i(clk), .nrst_i(nrst),
		.bit_req(i_ssic_if.bit_req), .bit_op(i_ssic_if.bit_op),
		.bit_addr(i_ssic_if.bit_addr), .bit_sel(i_ssic_if.bit_sel),
		.bit_rdata(i_ssic_if.bit_rdata), .bit_rvalid(i_ssic_if.bit_rvalid),
		.irq_req(i_ssic_if.irq_req), .irq_vec(i_ssic_if.irq_vec),
		.ack(i_ssic_if.ack), .return_from_handler_instr(i_ssic_if.return_from_handler_instr));

	// Timer B event pulses, counted even while the pin is masked
	always @(posedge clk) begin
		if (tbe === 1'b1) nb <= nb + 1;
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	// One bit instruction; p is word * 4 + bit, gap cycle after it
	task automatic cmd(input ssic_op_type o, input logic [11:0] p);
		cv = 1'b1;
		co = o;
		ca = p[11:2];
		cb = p[1:0];
		@(negedge clk);
		cv = 1'b0;
		@(negedge clk);
	endtask

	// Test answer lands two edges after the strobe is taken
	task automatic tst(input logic [11:0] p, input logic e);
		cmd(SSIC_OP_TEST, p);
		@(negedge clk);
		chk("rvalid", 16'(rv), 16'h0001);
		chk("rdata", 16'(rd), 16'(e));
	endtask

	// Hold one event line for n samples
	task automatic evt(input int i, input int n);
		ev[i] = 1'b1;
		repeat (n) @(negedge clk);
		ev[i] = 1'b0;
		@(negedge clk);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 7; i++) cmd(SSIC_OP_SET, 12'(i == 0 ? 1 : 2 * i));
		for (int p = 0; p < 16; p++) tst(12'(p), p[0] && p > 2 && p < 14);
		tst(12'h010, 1'b0);
	endtask

	task automatic t_prio();
		for (int i = 0; i < 6; i++) cmd(SSIC_OP_CLEAR, 12'(3 + 2 * i));
		for (int i = 0; i < 6; i++) evt(i, i < 2 ? 3 : 1);
		repeat (3) @(negedge clk);
		chk("irq_off", 16'(i_ssic_if.irq_req), 16'h0000);
		chk("tb_evt", 16'(nb), 16'h0001);
		// Each round retires the winner, so the next one must surface
		for (int i = 0; i < 6; i++) begin
			if (i == 0) cmd(SSIC_OP_SET, 12'h000);
			else begin
				r = 1'b1;
				@(negedge clk);
				r = 1'b0;
			end
			for (int k = 0; k < 40 && fin !== 1'b1; k++) @(negedge clk);
			chk("finish", 16'(fin), 16'h0001);
			@(negedge clk);
			chk("push2", 16'({psh, fch}), 16'h0002);
			chk("finish_once", 16'(fin), 16'h0000);
			chk("ie_cleared", 16'(ie), 16'h0000);
			@(negedge clk);
			chk("fetch", 16'({psh, fch}), 16'h0003);
			chk("vector", fa, 16'h0002 + 16'(2 * i));
			@(negedge clk);
			chk("seq_end", 16'({psh, fch}), 16'h0000);
			cmd(SSIC_OP_CLEAR, 12'(2 + 2 * i));
		end
		r = 1'b1;
		@(negedge clk);
		r = 1'b0;
		repeat (4) @(negedge clk);
		chk("ie_back", 16'(ie), 16'h0001);
		chk("irq_idle", 16'(i_ssic_if.irq_req), 16'h0000);
	endtask

	task automatic t_misc();
		for (int i = 0; i < 6; i++) cmd(SSIC_OP_SET, 12'(3 + 2 * i));
		evt(0, 2);
		evt(1, 3);
		repeat (3) @(negedge clk);
		// Clear of timer C flag meets its overflow at the same edge
		cv = 1'b1;
		co = SSIC_OP_CLEAR;
		ca = 10'h002;
		cb = 2'h2;
		@(negedge clk);
		cv = 1'b0;
		ev[4] = 1'b1;
		@(negedge clk);
		ev[4] = 1'b0;
		ab = 1'b1;
		@(negedge clk);
		ab = 1'b0;
		repeat (3) @(negedge clk);
		tst(12'h002, 1'b0);
		tst(12'h004, 1'b1);
		tst(12'h00A, 1'b1);
		tst(12'h00C, 1'b1);
		chk("irq_masked", 16'(i_ssic_if.irq_req), 16'h0000);
		chk("tb_evt2", 16'(nb), 16'h0002);
		// Software clear of the enable bit itself
		cmd(SSIC_OP_CLEAR, 12'h000);
		chk("ie_sw_clr", 16'(ie), 16'h0000);
	endtask

	// Reset in mid-run must bring the enable, the ext0 mask and the timer A and serial flags back
	task automatic t_rerst();
		cmd(SSIC_OP_SET, 12'h000);
		cmd(SSIC_OP_CLEAR, 12'h003);
		evt(2, 1);
		chk("ie_pre", 16'(ie), 16'h0001);
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		chk("ie_rst", 16'(ie), 16'h0000);
		tst(12'h000, 1'b0);
		tst(12'h003, 1'b1);
		tst(12'h006, 1'b0);
		tst(12'h00C, 1'b0);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence; reset spans three cycles
	initial begin
		nrst = 1'b0;
		ev = 6'h00;
		ab = 1'b0;
		r = 1'b0;
		cv = 1'b0;
		co = SSIC_OP_NONE;
		ca = 10'h000;
		cb = 2'h0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		t_reset();
		t_prio();
		t_misc();
		t_rerst();
		close_out();
	end

	// Whole run needs about 225 cycles; cut a hang at 10000 cycles, over forty times that
	initial begin
		#50000;
		err_total++;
		close_out();
	end
endmodule
